// file: shared/rmio_defines.svh
// offsets, field positions, reset values and clock rate of the remote mcu i/o port block
// assumes a 32-bit apb slave with word-aligned registers
`ifndef RMIO_DEFINES_SVH
`define RMIO_DEFINES_SVH

`define RMIO_CLK_HZ 10000000
// register byte offsets
`define RMIO_OFF_CMD 12'h000
`define RMIO_OFF_BITLAT 12'h004
`define RMIO_OFF_NIBA 12'h008
`define RMIO_OFF_NIBB 12'h00c
`define RMIO_OFF_IRQP 12'h010
`define RMIO_OFF_DRVP 12'h014
`define RMIO_OFF_DRVSEL 12'h018
`define RMIO_OFF_PULLUP 12'h01c
`define RMIO_OFF_WAKEEN 12'h020
`define RMIO_OFF_TMRCFG 12'h024
`define RMIO_OFF_PINS 12'h028
`define RMIO_OFF_SKIP 12'h02c
`define RMIO_OFF_IRQSTAT 12'h030
`define RMIO_OFF_IRQMASK 12'h034
// command register fields
`define RMIO_CMD_OP_LSB 8
`define RMIO_CMD_OP_W 3
`define RMIO_CMD_BIT_W 3
// status bit positions
`define RMIO_ST_WAKE 0
`define RMIO_ST_EXTA 1
`define RMIO_ST_EXTB 2
`define RMIO_ST_W 3
// timer config fields
`define RMIO_TC_EVIN 0
`define RMIO_TC_UFOUT 1
`define RMIO_TC_UFSEL 2
`define RMIO_TC_PWMOUT 3
// reset values: latches released (1), controls off
`define RMIO_RST_BITLAT 5'h1f
`define RMIO_RST_NIB 4'hf
`define RMIO_RST_PAIR 2'h3
`define RMIO_RST_CTRL 4'h0

`endif

// file: shared/rmio_pkg.sv
// types shared by the remote mcu i/o port block
// assumes the defines header is compiled alongside
package rmio_pkg;
	typedef enum logic [2:0] {
		RMIO_OP_NONE,
		RMIO_OP_SET_BIT,
		RMIO_OP_CLR_BIT,
		RMIO_OP_CLR_ALL,
		RMIO_OP_SKIP_TEST,
		RMIO_OP_SET_OUT,
		RMIO_OP_CLR_OUT
	} rmio_op_t;
endpackage

// file: rtl/rmio_ports.sv
// i/o port unit of a small 4-bit controller, reached over apb
// assumes pin inputs synchronous to mclk; pad wires are resolved outside from the enables
//
// Overview of operation
// RULE_01: each of the five bit-port pins is its own single-bit i/o, addressed by bit position.
// RULE_02: the bit port is read only by a skip test that reports whether the selected pin is low.
// RULE_03: the lower four bit-port pins drive open-drain or push-pull by a control field; inputs need latch 1 and open-drain.
// RULE_04: both nibble ports are read and written whole, open-drain, with per-bit pull-up and wakeup enables.
// RULE_05: the interrupt-shared pair port is open-drain with switched pull-up and wakeup; inputs need latch 1.
// RULE_06: the drive-select pair port chooses open-drain or push-pull per pin; inputs need latch 1.
// RULE_07: the output-only pin is push-pull, set and cleared by its own commands, shared with pwm output.
// RULE_08: the input-only pin is readable and has a switchable wakeup.
// RULE_09: the timer pin feeds the first timer event input and can output a timer underflow divided by two.
// RULE_10: the output-only pin can carry the third timer pwm waveform.
// RULE_11: the fifth bit-port pin stays readable with timer output on and fully usable with timer input.
// RULE_12: the interrupt-shared pins keep their port function while the interrupts are active.
// RULE_13: the two external interrupt inputs raise requests and each has a switchable wakeup.
// RULE_14: each port holds its output in a latch, and a 1 on an open-drain pin releases it.
`timescale 1ns/1ps
`include "rmio_defines.svh"

module rmio_ports (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// bit port
	input wire logic [4:0] bitPortPinsIn,
	output logic [4:0] bitPortPinsOut,
	output logic [4:0] bitPortPinsOe,
	// nibble ports
	input wire logic [3:0] nibblePortAPinsIn,
	output logic [3:0] nibblePortAPinsOe,
	output logic [3:0] pullupEnableA,
	input wire logic [3:0] nibblePortBPinsIn,
	output logic [3:0] nibblePortBPinsOe,
	output logic [3:0] pullupEnableB,
	// pair ports
	input wire logic [1:0] irqSharedPortPinsIn,
	output logic [1:0] irqSharedPortPinsOe,
	output logic [1:0] pullupEnableIrqPort,
	input wire logic [1:0] driveSelectPortPinsIn,
	output logic [1:0] driveSelectPortPinsOut,
	output logic [1:0] driveSelectPortPinsOe,
	// single-bit ports
	output logic pwmOutputPin,
	input wire logic inputOnlyPin,
	// timer side
	input wire logic timer1Underflow,
	input wire logic timer2Underflow,
	input wire logic timer3Pwm,
	output logic timerEventClk,
	// system side
	output logic wakeupReq,
	output logic irqOut
);
	logic [4:0] bitLat_r;
	logic [3:0] nibA_r, nibB_r;
	logic [1:0] irqP_r, drvP_r;
	logic outPin_r;
	logic [3:0] bitDrvSel_r;
	logic [1:0] pairDrvSel_r;
	logic [3:0] puA_r, puB_r;
	logic [1:0] puIrq_r;
	logic [3:0] wakeA_r, wakeB_r;
	logic [2:0] wakeMisc_r;
	logic [3:0] tmrCfg_r;
	logic skipFlag_r;
	logic ufDiv_r;
	logic [2:0] stat_r, mask_r;
	logic [1:0] extPrev_r;
	logic [31:0] rdata_nxt;
	logic hit_nxt;
	logic wrAcc, cmdWr;
	rmio_pkg::rmio_op_t op;
	logic [2:0] bitSel;
	logic timerOutOn, wakeEvent;
	logic [1:0] extRise;
	logic [2:0] statSet;

	// single-cycle access: the slave answers in the first access cycle
	// pready gating keeps a stretched access from committing a second time
	assign wrAcc = psel & penable & pready & pwrite;
	assign cmdWr = wrAcc & (paddr == `RMIO_OFF_CMD);
	assign op = rmio_pkg::rmio_op_t'(pwdata[`RMIO_CMD_OP_LSB +: `RMIO_CMD_OP_W]);
	assign bitSel = pwdata[`RMIO_CMD_BIT_W-1:0];
	assign timerOutOn = tmrCfg_r[`RMIO_TC_UFOUT];

	// bit latch: per-bit set/clear by position, clear-all, or whole write
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bitLat_r <= `RMIO_RST_BITLAT;
		end else if (cmdWr && op == rmio_pkg::RMIO_OP_SET_BIT && bitSel < 3'h5) begin
			bitLat_r[bitSel] <= 1'b1; // RULE_01
		end else if (cmdWr && op == rmio_pkg::RMIO_OP_CLR_BIT && bitSel < 3'h5) begin
			bitLat_r[bitSel] <= 1'b0; // RULE_01
		end else if (cmdWr && op == rmio_pkg::RMIO_OP_CLR_ALL) begin
			bitLat_r <= 5'h00;
		end else if (wrAcc && paddr == `RMIO_OFF_BITLAT) begin
			bitLat_r <= pwdata[4:0];
		end
	end

	// skip test reports a low pin; out-of-range position never skips
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			skipFlag_r <= 1'b0;
		end else if (cmdWr && op == rmio_pkg::RMIO_OP_SKIP_TEST) begin
			skipFlag_r <= (bitSel < 3'h5) ? ~bitPortPinsIn[bitSel] : 1'b0; // RULE_02 RULE_11
		end
	end

	// port latches and output-only pin latch
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			nibA_r <= `RMIO_RST_NIB;
			nibB_r <= `RMIO_RST_NIB;
			irqP_r <= `RMIO_RST_PAIR;
			drvP_r <= `RMIO_RST_PAIR;
			outPin_r <= 1'b0;
		end else begin
			if (wrAcc && paddr == `RMIO_OFF_NIBA) begin
				nibA_r <= pwdata[3:0]; // RULE_04 RULE_14
			end
			if (wrAcc && paddr == `RMIO_OFF_NIBB) begin
				nibB_r <= pwdata[3:0]; // RULE_04 RULE_14
			end
			if (wrAcc && paddr == `RMIO_OFF_IRQP) begin
				irqP_r <= pwdata[1:0]; // RULE_05 RULE_14
			end
			if (wrAcc && paddr == `RMIO_OFF_DRVP) begin
				drvP_r <= pwdata[1:0]; // RULE_06 RULE_14
			end
			if (cmdWr && op == rmio_pkg::RMIO_OP_SET_OUT) begin
				outPin_r <= 1'b1; // RULE_07
			end else if (cmdWr && op == rmio_pkg::RMIO_OP_CLR_OUT) begin
				outPin_r <= 1'b0; // RULE_07
			end
		end
	end

	// drive, pull-up, wakeup and timer configuration
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bitDrvSel_r <= `RMIO_RST_CTRL;
			pairDrvSel_r <= 2'h0;
			puA_r <= `RMIO_RST_CTRL;
			puB_r <= `RMIO_RST_CTRL;
			puIrq_r <= 2'h0;
			wakeA_r <= `RMIO_RST_CTRL;
			wakeB_r <= `RMIO_RST_CTRL;
			wakeMisc_r <= 3'h0;
			tmrCfg_r <= `RMIO_RST_CTRL;
		end else if (wrAcc) begin
			if (paddr == `RMIO_OFF_DRVSEL) begin
				bitDrvSel_r <= pwdata[3:0]; // RULE_03
				pairDrvSel_r <= pwdata[5:4]; // RULE_06
			end else if (paddr == `RMIO_OFF_PULLUP) begin
				puA_r <= pwdata[3:0]; // RULE_04
				puB_r <= pwdata[7:4]; // RULE_04
				puIrq_r <= pwdata[9:8]; // RULE_05
			end else if (paddr == `RMIO_OFF_WAKEEN) begin
				wakeA_r <= pwdata[3:0];
				wakeB_r <= pwdata[7:4];
				wakeMisc_r <= pwdata[10:8]; // RULE_08 RULE_13
			end else if (paddr == `RMIO_OFF_TMRCFG) begin
				tmrCfg_r <= pwdata[3:0];
			end
		end
	end

	// underflow divided by two: toggles on each selected underflow pulse
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ufDiv_r <= 1'b0;
		end else if (tmrCfg_r[`RMIO_TC_UFSEL] ? timer2Underflow : timer1Underflow) begin
			ufDiv_r <= ~ufDiv_r; // RULE_09
		end
	end

	// pad drivers; open-drain pins enable only to pull low
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bitPortPinsOut <= 5'h00;
			bitPortPinsOe <= 5'h00;
			nibblePortAPinsOe <= 4'h0;
			nibblePortBPinsOe <= 4'h0;
			irqSharedPortPinsOe <= 2'h0;
			driveSelectPortPinsOut <= 2'h0;
			driveSelectPortPinsOe <= 2'h0;
			pwmOutputPin <= 1'b0;
			pullupEnableA <= 4'h0;
			pullupEnableB <= 4'h0;
			pullupEnableIrqPort <= 2'h0;
			timerEventClk <= 1'b0;
		end else begin
			bitPortPinsOut[3:0] <= bitLat_r[3:0];
			bitPortPinsOe[3:0] <= bitDrvSel_r | ~bitLat_r[3:0]; // RULE_03 RULE_14
			// fifth pin: open-drain, timer output takes the latch's place
			bitPortPinsOut[4] <= 1'b0;
			bitPortPinsOe[4] <= timerOutOn ? ~ufDiv_r : ~bitLat_r[4]; // RULE_09 RULE_11
			nibblePortAPinsOe <= ~nibA_r; // RULE_04 RULE_14
			nibblePortBPinsOe <= ~nibB_r; // RULE_04 RULE_14
			irqSharedPortPinsOe <= ~irqP_r; // RULE_05 RULE_12
			driveSelectPortPinsOut <= drvP_r;
			driveSelectPortPinsOe <= pairDrvSel_r | ~drvP_r; // RULE_06
			pwmOutputPin <= tmrCfg_r[`RMIO_TC_PWMOUT] ? timer3Pwm : outPin_r; // RULE_07 RULE_10
			pullupEnableA <= puA_r;
			pullupEnableB <= puB_r;
			pullupEnableIrqPort <= puIrq_r; // RULE_05
			timerEventClk <= tmrCfg_r[`RMIO_TC_EVIN] & bitPortPinsIn[4]; // RULE_09 RULE_11
		end
	end

	// events: low key level wakes, rising edges on shared pins are interrupt requests
	assign wakeEvent = (|(wakeA_r & ~nibblePortAPinsIn)) | (|(wakeB_r & ~nibblePortBPinsIn))
		| (wakeMisc_r[0] & ~inputOnlyPin) | (|(wakeMisc_r[2:1] & ~irqSharedPortPinsIn)); // RULE_08 RULE_13
	assign extRise = irqSharedPortPinsIn & ~extPrev_r;
	assign statSet = {extRise[1], extRise[0], wakeEvent};

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			// idle-high lines must not look like a rise on the first edge after reset
			extPrev_r <= `RMIO_RST_PAIR;
			stat_r <= 3'h0;
			mask_r <= 3'h0;
			wakeupReq <= 1'b0;
			irqOut <= 1'b0;
		end else begin
			extPrev_r <= irqSharedPortPinsIn;
			// set beats a simultaneous write-one clear
			if (wrAcc && paddr == `RMIO_OFF_IRQSTAT) begin
				stat_r <= (stat_r & ~pwdata[2:0]) | statSet; // RULE_13
			end else begin
				stat_r <= stat_r | statSet; // RULE_13
			end
			if (wrAcc && paddr == `RMIO_OFF_IRQMASK) begin
				mask_r <= pwdata[2:0];
			end
			wakeupReq <= wakeEvent;
			irqOut <= |(stat_r & mask_r);
		end
	end

	// read decode
	always_comb begin
		rdata_nxt = 32'h0;
		hit_nxt = 1'b1;
		if (paddr == `RMIO_OFF_CMD) begin
			rdata_nxt = 32'h0;
		end else if (paddr == `RMIO_OFF_BITLAT) begin
			rdata_nxt[4:0] = bitLat_r;
		end else if (paddr == `RMIO_OFF_NIBA) begin
			rdata_nxt[3:0] = nibblePortAPinsIn; // RULE_04
		end else if (paddr == `RMIO_OFF_NIBB) begin
			rdata_nxt[3:0] = nibblePortBPinsIn; // RULE_04
		end else if (paddr == `RMIO_OFF_IRQP) begin
			rdata_nxt[1:0] = irqSharedPortPinsIn; // RULE_12
		end else if (paddr == `RMIO_OFF_DRVP) begin
			rdata_nxt[1:0] = driveSelectPortPinsIn;
		end else if (paddr == `RMIO_OFF_DRVSEL) begin
			rdata_nxt[5:0] = {pairDrvSel_r, bitDrvSel_r};
		end else if (paddr == `RMIO_OFF_PULLUP) begin
			rdata_nxt[9:0] = {puIrq_r, puB_r, puA_r};
		end else if (paddr == `RMIO_OFF_WAKEEN) begin
			rdata_nxt[10:0] = {wakeMisc_r, wakeB_r, wakeA_r};
		end else if (paddr == `RMIO_OFF_TMRCFG) begin
			rdata_nxt[3:0] = tmrCfg_r;
		end else if (paddr == `RMIO_OFF_PINS) begin
			rdata_nxt[1:0] = {outPin_r, inputOnlyPin}; // RULE_08
		end else if (paddr == `RMIO_OFF_SKIP) begin
			rdata_nxt[0] = skipFlag_r; // RULE_02
		end else if (paddr == `RMIO_OFF_IRQSTAT) begin
			rdata_nxt[2:0] = stat_r;
		end else if (paddr == `RMIO_OFF_IRQMASK) begin
			rdata_nxt[2:0] = mask_r;
		end else begin
			hit_nxt = 1'b0;
		end
	end

	// ready and read data register in setup, so answer sits in the first access cycle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit_nxt;
			prdata <= (psel & ~penable & ~pwrite) ? rdata_nxt : 32'h0;
		end
	end

	// checks
	skip_low_pin_a: assert property (@(posedge mclk) disable iff (reset)
		cmdWr && op == rmio_pkg::RMIO_OP_SKIP_TEST && bitSel == 3'h2 |=> skipFlag_r == ~$past(bitPortPinsIn[2]))
		else $error("skip flag does not follow selected pin"); // RULE_02
	bit_set_a: assert property (@(posedge mclk) disable iff (reset)
		cmdWr && op == rmio_pkg::RMIO_OP_SET_BIT && bitSel < 3'h5 |=> bitLat_r[$past(bitSel)])
		else $error("bit set command lost"); // RULE_01
	drive_bit_a: assert property (@(posedge mclk) disable iff (reset)
		bitLat_r[0] && !bitDrvSel_r[0] |=> !bitPortPinsOe[0])
		else $error("open-drain pin not released"); // RULE_03
	nib_release_a: assert property (@(posedge mclk) disable iff (reset)
		wrAcc && paddr == `RMIO_OFF_NIBA |=> ##1 nibblePortAPinsOe == ~$past(pwdata[3:0], 2))
		else $error("nibble port output wrong"); // RULE_04
	pair_push_a: assert property (@(posedge mclk) disable iff (reset)
		pairDrvSel_r[1] |=> driveSelectPortPinsOe[1])
		else $error("push-pull pin not driven"); // RULE_06
	out_pin_a: assert property (@(posedge mclk) disable iff (reset)
		cmdWr && op == rmio_pkg::RMIO_OP_SET_OUT && !tmrCfg_r[`RMIO_TC_PWMOUT] ##1 !tmrCfg_r[`RMIO_TC_PWMOUT]
		|=> pwmOutputPin)
		else $error("output-only pin not set"); // RULE_07
	pwm_route_a: assert property (@(posedge mclk) disable iff (reset)
		tmrCfg_r[`RMIO_TC_PWMOUT] |=> pwmOutputPin == $past(timer3Pwm))
		else $error("pwm not routed"); // RULE_10
	uf_toggle_a: assert property (@(posedge mclk) disable iff (reset)
		!tmrCfg_r[`RMIO_TC_UFSEL] && timer1Underflow |=> ufDiv_r != $past(ufDiv_r))
		else $error("underflow divider stuck"); // RULE_09
	ext_sticky_a: assert property (@(posedge mclk) disable iff (reset)
		extRise[0] |=> stat_r[`RMIO_ST_EXTA])
		else $error("interrupt request lost"); // RULE_13
	irq_level_a: assert property (@(posedge mclk) disable iff (reset)
		|(stat_r & mask_r) |=> irqOut)
		else $error("interrupt output low"); // RULE_13
	wake_input_a: assert property (@(posedge mclk) disable iff (reset)
		wakeMisc_r[0] && !inputOnlyPin |=> wakeupReq && stat_r[`RMIO_ST_WAKE])
		else $error("input-only wakeup missed"); // RULE_08
	apb_ready_a: assert property (@(posedge mclk) disable iff (reset)
		psel && !penable |=> pready)
		else $error("apb answer late");
	cov_skip_c: cover property (@(posedge mclk) disable iff (reset) skipFlag_r);
	cov_wake_c: cover property (@(posedge mclk) disable iff (reset) wakeupReq);
	cov_irq_c: cover property (@(posedge mclk) disable iff (reset) irqOut);
	cov_pwm_c: cover property (@(posedge mclk) disable iff (reset) tmrCfg_r[`RMIO_TC_PWMOUT] && pwmOutputPin);
endmodule

// file: sim/rmio_pad_model.sv
// pad level model: keys, loads and floating lines at the port pins
// assumes the bench gives key presses and a float pattern; a released line without pull shows the pattern
`timescale 1ns/1ps

module rmio_pad_model (
	// design drive
	input wire logic [4:0] bitOut,
	input wire logic [4:0] bitOe,
	input wire logic [3:0] aOe,
	input wire logic [3:0] aPu,
	input wire logic [3:0] bOe,
	input wire logic [3:0] bPu,
	input wire logic [1:0] iOe,
	input wire logic [1:0] iPu,
	input wire logic [1:0] dOut,
	input wire logic [1:0] dOe,
	// board side: [4:0] bit, [8:5] a, [12:9] b, [14:13] irq pair, [16:15] drive pair
	input wire logic [16:0] keys,
	input wire logic [16:0] flt,
	// resolved pad levels
	output logic [4:0] bitPad,
	output logic [3:0] aPad,
	output logic [3:0] bPad,
	output logic [1:0] iPad,
	output logic [1:0] dPad
);
	// a pressed key pulls an undriven line low; without pull-up a released line floats to the bench pattern
	assign bitPad = (bitOe & bitOut) | (~bitOe & ~keys[4:0] & flt[4:0]);
	assign aPad = ~aOe & ~keys[8:5] & (aPu | flt[8:5]);
	assign bPad = ~bOe & ~keys[12:9] & (bPu | flt[12:9]);
	assign iPad = ~iOe & ~keys[14:13] & (iPu | flt[14:13]);
	assign dPad = (dOe & dOut) | (~dOe & ~keys[16:15] & flt[16:15]);
endmodule

// file: sim/remote_mcu_io_ports_tb_top.sv
// self-checking bench of the i/o port block: apb master, pad model and integer reference state
// assumes the defines header is on the include path and the package is compiled first
`timescale 1ns/1ps
`include "rmio_defines.svh"

module remote_mcu_io_ports_tb_top;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, pwm, evClk, wake, irq;
	logic [4:0] bitIn, bitOut, bitOe;
	logic [3:0] aIn, aOe, aPu, bIn, bOe, bPu;
	logic [1:0] iIn, iOe, iPu, dIn, dOut, dOe;
	logic inOnly = 1'b1, uf1 = 1'b0, uf2 = 1'b0, pwmIn = 1'b0;
	logic [16:0] keys = 17'h0, flt = 17'h0;
	logic [31:0] seed = 32'h0b22;
	int fails = 0, checks = 0, cyc = 0, outL = 0, div = 0, k, j, p;
	logic [11:0] adr [10] = '{`RMIO_OFF_CMD, `RMIO_OFF_BITLAT, `RMIO_OFF_NIBA, `RMIO_OFF_NIBB, `RMIO_OFF_IRQP,
		`RMIO_OFF_DRVP, `RMIO_OFF_DRVSEL, `RMIO_OFF_PULLUP, `RMIO_OFF_WAKEEN, `RMIO_OFF_TMRCFG};
	int msk [10] = '{0, 31, 15, 15, 3, 3, 63, 1023, 2047, 15};
	int lat [10] = '{0, 31, 15, 15, 3, 3, 0, 0, 0, 0};
	int wkb [5] = '{0, 7, 8, 9, 10};
	int kyb [5] = '{32, 4096, 0, 8192, 16384};

	always #50 mclk = ~mclk;

	rmio_ports i_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bitPortPinsIn(bitIn),
		.bitPortPinsOut(bitOut), .bitPortPinsOe(bitOe), .nibblePortAPinsIn(aIn), .nibblePortAPinsOe(aOe),
		.pullupEnableA(aPu), .nibblePortBPinsIn(bIn), .nibblePortBPinsOe(bOe), .pullupEnableB(bPu),
		.irqSharedPortPinsIn(iIn), .irqSharedPortPinsOe(iOe), .pullupEnableIrqPort(iPu),
		.driveSelectPortPinsIn(dIn), .driveSelectPortPinsOut(dOut), .driveSelectPortPinsOe(dOe),
		.pwmOutputPin(pwm), .inputOnlyPin(inOnly), .timer1Underflow(uf1), .timer2Underflow(uf2),
		.timer3Pwm(pwmIn), .timerEventClk(evClk), .wakeupReq(wake), .irqOut(irq));
	rmio_pad_model i_pads (.bitOut(bitOut), .bitOe(bitOe), .aOe(aOe), .aPu(aPu), .bOe(bOe), .bPu(bPu),
		.iOe(iOe), .iPu(iPu), .dOut(dOut), .dOe(dOe), .keys(keys), .flt(flt), .bitPad(bitIn), .aPad(aIn),
		.bPad(bIn), .iPad(iIn), .dPad(dIn));

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic int bitOeE();
		// fifth pin follows the divider instead of its latch while underflow output is on
		return ((lat[6] & 15) | (~lat[1] & 15) | ((lat[9] & 2) ? ((~div & 1) << 4) : (~lat[1] & 16))) & 31;
	endfunction
	function automatic int padE(int oe, int dv, int pu, int sh, int w);
		return ((oe & dv) | (~oe & ~(int'(keys) >> sh) & (pu | (int'(flt) >> sh)))) & ((1 << w) - 1);
	endfunction
	task automatic chkRead(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD read at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkPin(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD pin at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// request held from setup until pready is seen high; data taken at that edge only
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// no wait count assumed; only the cycle ceiling ends a hung access
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input int d);
		apb(1'b1, a, 32'(d));
	endtask
	task automatic rdc(input logic [11:0] a, input int e);
		apb(1'b0, a, 32'h0);
		chkRead(rd, 32'(e));
		chkRead(32'(er), 32'h0);
	endtask
	task automatic cmd(input rmio_pkg::rmio_op_t o, input int ps);
		wr(`RMIO_OFF_CMD, (int'(o) << `RMIO_CMD_OP_LSB) | (ps & 7));
	endtask
	// pin outputs trail the latch by one edge, so three edges cover every update
	task automatic settle();
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task automatic chkPorts();
		chkPin(32'(bitOe), 32'(bitOeE()));
		chkPin(32'(bitOut), 32'(lat[1] & 15));
		chkPin(32'({aOe, bOe, iOe}), 32'(((~lat[2] & 15) << 6) | ((~lat[3] & 15) << 2) | (~lat[4] & 3)));
		chkPin(32'({iPu, bPu, aPu}), 32'(lat[7]));
		chkPin(32'({dOe, dOut}), 32'(((((lat[6] >> 4) | ~lat[5]) & 3) << 2) | (lat[5] & 3)));
		chkPin(32'(pwm), 32'((lat[9] & 8) ? int'(pwmIn) : outL));
	endtask
	task automatic close_out();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			close_out();
		end
	end

	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		settle();
		chkPorts();
		for (int r = 0; r < 10; r++) begin
			if (r < 2 || r > 5) rdc(adr[r], lat[r]);
		end
		rdc(`RMIO_OFF_PINS, 1);
		apb(1'b0, 12'h040, 32'h0);
		chkRead(32'(er), 32'h1);
		chkRead(rd, 32'h0);
		$display("test reset done");
		for (int it = 0; it < 30; it++) begin
			@(posedge mclk);
			keys <= 17'(xs());
			flt <= 17'(xs());
			k = xs() % 8;
			// kept non-negative so the modulo op choice stays in range
			j = int'(xs() >> 1);
			p = (j >> 4) % 8;
			if (k == 0) begin
				cmd(rmio_pkg::rmio_op_t'(1 + j % 3), p);
				if (j % 3 == 0 && p < 5) lat[1] |= 1 << p;
				if (j % 3 == 1 && p < 5) lat[1] &= ~(1 << p);
				if (j % 3 == 2) lat[1] = 0;
			end else begin
				lat[k] = j & msk[k];
				wr(adr[k], lat[k]);
			end
			settle();
			chkPorts();
			rdc(adr[1], lat[1]);
			rdc(adr[6], lat[6]);
			rdc(adr[7], lat[7]);
			rdc(`RMIO_OFF_NIBA, padE(~lat[2], 0, lat[7], 5, 4));
			rdc(`RMIO_OFF_NIBB, padE(~lat[3], 0, lat[7] >> 4, 9, 4));
			rdc(`RMIO_OFF_IRQP, padE(~lat[4], 0, lat[7] >> 8, 13, 2));
			rdc(`RMIO_OFF_DRVP, padE(((lat[6] >> 4) | ~lat[5]), lat[5] & (lat[6] >> 4), 0, 15, 2));
			cmd(rmio_pkg::RMIO_OP_SKIP_TEST, j >> 8);
			p = (j >> 8) % 8;
			rdc(`RMIO_OFF_SKIP, p < 5 ? (~padE(bitOeE(), lat[1] & 15, 0, 0, 5) >> p) & 1 : 0);
		end
		$display("test port latches done");
		@(posedge mclk);
		keys <= 17'h0;
		lat[1] = 31;
		wr(adr[1], 31);
		lat[9] = 1;
		wr(adr[9], 1);
		for (int t = 0; t < 2; t++) begin
			@(posedge mclk);
			flt <= 17'(t << 4);
			settle();
			chkPin(32'(evClk), 32'(t));
			cmd(rmio_pkg::RMIO_OP_SKIP_TEST, 4);
			rdc(`RMIO_OFF_SKIP, 1 - t);
		end
		for (int t = 0; t < 4; t++) begin
			lat[9] = (t < 2) ? 3 : 7;
			wr(adr[9], lat[9]);
			@(posedge mclk);
			uf1 <= ~t[0];
			uf2 <= t[0];
			@(posedge mclk);
			uf1 <= 1'b0;
			uf2 <= 1'b0;
			if (t == 0 || t == 3) div ^= 1;
			settle();
			chkPorts();
			cmd(rmio_pkg::RMIO_OP_SKIP_TEST, 4);
			rdc(`RMIO_OFF_SKIP, (bitOeE() >> 4) & 1);
		end
		lat[9] = 0;
		wr(adr[9], 0);
		for (int t = 0; t < 4; t++) begin
			if (t == 0) cmd(rmio_pkg::RMIO_OP_SET_OUT, 0);
			if (t == 1) cmd(rmio_pkg::RMIO_OP_CLR_OUT, 0);
			if (t == 2) lat[9] = 8;
			if (t == 2) wr(adr[9], 8);
			outL = (t == 0);
			@(posedge mclk);
			pwmIn <= (t == 2);
			inOnly <= t[0];
			settle();
			chkPorts();
			rdc(`RMIO_OFF_PINS, (outL << 1) | t[0]);
		end
		$display("test timer pins done");
		lat[9] = 0;
		wr(adr[9], 0);
		lat[4] = 3;
		wr(adr[4], 3);
		lat[7] = 0;
		wr(adr[7], 0);
		@(posedge mclk);
		flt <= 17'h0;
		inOnly <= 1'b1;
		settle();
		wr(`RMIO_OFF_IRQSTAT, 7);
		wr(`RMIO_OFF_IRQMASK, 0);
		for (int t = 0; t < 2; t++) begin
			@(posedge mclk);
			flt <= 17'(1 << (13 + t));
			settle();
			rdc(`RMIO_OFF_IRQSTAT, 2 << t);
			chkPin(32'(irq), 32'h0);
			wr(`RMIO_OFF_IRQMASK, 2 << t);
			settle();
			chkPin(32'(irq), 32'h1);
			wr(`RMIO_OFF_IRQSTAT, 2 << t);
			settle();
			chkPin(32'(irq), 32'h0);
			@(posedge mclk);
			flt <= 17'h0;
			settle();
			rdc(`RMIO_OFF_IRQSTAT, 0);
		end
		// released latches and pull-ups, or a let-go key still reads low and keeps waking
		lat[2] = 15;
		wr(adr[2], 15);
		lat[3] = 15;
		wr(adr[3], 15);
		lat[7] = 1023;
		wr(adr[7], 1023);
		wr(`RMIO_OFF_IRQMASK, 1);
		for (int t = 0; t < 5; t++) begin
			wr(adr[8], 0);
			@(posedge mclk);
			keys <= 17'(kyb[t]);
			inOnly <= (wkb[t] != 8);
			settle();
			chkPin(32'(wake), 32'h0);
			wr(adr[8], 1 << wkb[t]);
			settle();
			chkPin(32'(wake), 32'h1);
			chkPin(32'(irq), 32'h1);
			@(posedge mclk);
			keys <= 17'h0;
			inOnly <= 1'b1;
			settle();
			wr(`RMIO_OFF_IRQSTAT, 7);
			settle();
			rdc(`RMIO_OFF_IRQSTAT, 0);
		end
		$display("test interrupts done");
		close_out();
	end
endmodule
